// File: hw/usb_legacy_smi_status_control.sv
`timescale 1ns/10ps
module usb_legacy_smi_status_control (
   input  wire logic                           ref_clk_in,
   input  wire logic                           resetn_in,
   input  wire logic                           ce_in,
   input  wire legacy_smi_pkg::cfg_req_t       cfg_req_in,
   input  wire legacy_smi_pkg::trap_events_t   trap_events_in,
   input  wire logic                           usb_irq_pending_in,
   input  wire logic                           passthru_active_in,
   output logic [15:0]                         cfg_rdata_out,
   output logic                                cfg_rd_valid_out,
   output logic                                system_mgmt_irq_n_out,
   output logic                                pci_irq_out
);
   import legacy_smi_pkg::*;

   // sticky flags and their enables
   logic [STICKY_COUNT-1:0] sticky_set;
   logic [STICKY_COUNT-1:0] sticky_clear;
   logic [STICKY_COUNT-1:0] sticky_flag;
   logic [STICKY_COUNT-1:0] sticky_en;
   logic [STICKY_COUNT-1:0] sticky_cause;

   // stored control state
   logic [7:0]              low_ctrl_q;
   logic [7:0]              low_ctrl_d;
   logic                    pci_irq_gate_enable_q;
   logic                    pci_irq_gate_enable_d;
   logic                    usb_irq_smi_flag_q;
   logic                    usb_irq_smi_flag_d;

   // bus decode
   logic                    reg_hit;
   logic                    low_wr;
   logic                    high_wr;

   // read path
   logic [7:0]              ctrl_view;
   logic [15:0]             reg_view;
   logic [15:0]             cfg_rdata_d;
   logic                    cfg_rd_valid_d;

   // interrupt outputs
   logic                    usb_cause;
   logic                    smi_cause;
   logic                    smi_suppress;
   logic                    system_mgmt_irq_n_d;
   logic                    pci_irq_d;

   function automatic logic addr_hits(input logic [7:0] addr);
      addr_hits = (addr == LEGACY_CTRL_OFFSET);
   endfunction

   // a write lands on one byte lane of this register
   function automatic logic lane_write(input cfg_req_t req, input logic lane_en);
      lane_write = req.wr_en & addr_hits(req.addr) & lane_en;
   endfunction

   // index i pairs with STICKY_FLAG_POS[i], so end of pass-through is index 0
   function automatic logic [STICKY_COUNT-1:0] event_vector(input trap_events_t ev);
      event_vector = {ev.port60_read,
                      ev.port60_write,
                      ev.port64_read,
                      ev.port64_write,
                      ev.end_passthru};
   endfunction

   assign reg_hit    = addr_hits(cfg_req_in.addr);
   assign low_wr     = lane_write(cfg_req_in, cfg_req_in.byte_en[0]);
   assign high_wr    = lane_write(cfg_req_in, cfg_req_in.byte_en[1]);
   assign sticky_set = event_vector(trap_events_in);

   // one sticky flag per trapped event
   genvar gi;
   generate
      for (gi = 0; gi < STICKY_COUNT; gi = gi + 1) begin : g_sticky
         localparam int FPOS = STICKY_FLAG_POS[gi];
         localparam int EPOS = STICKY_EN_POS[gi];
         // flags sit in the upper byte, cleared through its lane only
         assign sticky_clear[gi] = (FPOS >= PORT60_RD_FLAG_POS) &&
                                   high_wr && cfg_req_in.wdata[FPOS];
         assign sticky_en[gi]    = low_ctrl_q[EPOS];
         assign sticky_cause[gi] = sticky_flag[gi] & sticky_en[gi];
         sticky_event_flag u_flag (
            .ref_clk_in (ref_clk_in),
            .resetn_in  (resetn_in),
            .ce_in      (ce_in),
            .set_in     (sticky_set[gi]),
            .clear_in   (sticky_clear[gi]),
            .flag_out   (sticky_flag[gi])
         );
      end
   endgenerate

   // enables and pass-through control in the low byte
   always_comb begin
      low_ctrl_d = low_ctrl_q;
      if (low_wr) begin
         // bit 6 is a live status view, never stored
         low_ctrl_d = cfg_req_in.wdata[7:0] & LOW_BYTE_RW_MASK;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_ctrl_q <= LEGACY_CTRL_RESET[7:0];
      end else if (ce_in) begin
         low_ctrl_q <= low_ctrl_d;
      end
   end

   always_comb begin
      pci_irq_gate_enable_d = pci_irq_gate_enable_q;
      if (high_wr) begin
         pci_irq_gate_enable_d = cfg_req_in.wdata[PCI_IRQ_GATE_POS];
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pci_irq_gate_enable_q <= LEGACY_CTRL_RESET[PCI_IRQ_GATE_POS];
      end else if (ce_in) begin
         pci_irq_gate_enable_q <= pci_irq_gate_enable_d;
      end
   end

   // mirrors the pending usb interrupt, writes never touch it
   assign usb_irq_smi_flag_d = usb_irq_pending_in;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         usb_irq_smi_flag_q <= 1'b0;
      end else if (ce_in) begin
         usb_irq_smi_flag_q <= usb_irq_smi_flag_d;
      end
   end

   // lower byte: stored enables plus the live pass-through state
   always_comb begin
      ctrl_view                     = low_ctrl_q;
      ctrl_view[PASSTHRU_STATE_POS] = passthru_active_in;
   end

   // assembled register as software reads it
   always_comb begin
      reg_view                     = LEGACY_CTRL_ZERO;
      reg_view[7:0]                = ctrl_view;
      reg_view[RESERVED_POS]       = 1'b0;
      reg_view[PCI_IRQ_GATE_POS]   = pci_irq_gate_enable_q;
      reg_view[USB_IRQ_FLAG_POS]   = usb_irq_smi_flag_q;
      for (int i = 0; i < STICKY_COUNT; i++) begin
         reg_view[STICKY_FLAG_POS[i]] = sticky_flag[i];
      end
   end

   // unmapped addresses still answer, with zero
   always_comb begin
      cfg_rd_valid_d = cfg_req_in.rd_en;
      cfg_rdata_d    = cfg_rdata_out;
      if (cfg_req_in.rd_en) begin
         cfg_rdata_d = reg_hit ? reg_view : LEGACY_CTRL_ZERO;
      end
   end

   // read data holds until the next read
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_rdata_out <= LEGACY_CTRL_ZERO;
      end else if (ce_in) begin
         cfg_rdata_out <= cfg_rdata_d;
      end
   end

   // valid pulses for one cycle per read
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_rd_valid_out <= 1'b0;
      end else if (ce_in) begin
         cfg_rd_valid_out <= cfg_rd_valid_d;
      end
   end

   // any enabled cause raises smi while the gate pass-through enable is clear
   assign usb_cause    = usb_irq_smi_flag_q & low_ctrl_q[USB_IRQ_SMI_EN_POS];
   assign smi_cause    = (|sticky_cause) | usb_cause;
   // the gate pass-through enable silences smi, the live pass-through state does not
   assign smi_suppress = low_ctrl_q[GATE_PASSTHRU_EN_POS];
   assign system_mgmt_irq_n_d = ~(smi_cause & ~smi_suppress);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         system_mgmt_irq_n_out <= 1'b1;
      end else if (ce_in) begin
         system_mgmt_irq_n_out <= system_mgmt_irq_n_d;
      end
   end

   // pci interrupt gated by its enable, smi path is separate
   assign pci_irq_d = usb_irq_pending_in & pci_irq_gate_enable_q;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pci_irq_out <= 1'b0;
      end else if (ce_in) begin
         pci_irq_out <= pci_irq_d;
      end
   end

endmodule // usb_legacy_smi_status_control

// File: hw/legacy_smi_pkg.sv
package legacy_smi_pkg;

   localparam logic [7:0]  LEGACY_CTRL_OFFSET = 8'hc0;
   localparam logic [15:0] LEGACY_CTRL_RESET  = 16'h2000;
   localparam logic [15:0] LEGACY_CTRL_ZERO   = 16'h0000;

   // field positions
   localparam int END_PASSTHRU_FLAG_POS  = 15;
   localparam int RESERVED_POS           = 14;
   localparam int PCI_IRQ_GATE_POS       = 13;
   localparam int USB_IRQ_FLAG_POS       = 12;
   localparam int PORT64_WR_FLAG_POS     = 11;
   localparam int PORT64_RD_FLAG_POS     = 10;
   localparam int PORT60_WR_FLAG_POS     = 9;
   localparam int PORT60_RD_FLAG_POS     = 8;
   localparam int END_PASSTHRU_SMI_EN_POS = 7;
   localparam int PASSTHRU_STATE_POS     = 6;
   localparam int GATE_PASSTHRU_EN_POS   = 5;
   localparam int USB_IRQ_SMI_EN_POS     = 4;
   localparam int PORT64_WR_EN_POS       = 3;
   localparam int PORT64_RD_EN_POS       = 2;
   localparam int PORT60_WR_EN_POS       = 1;
   localparam int PORT60_RD_EN_POS       = 0;

   // write-one-to-clear flags and the enable each pairs with
   localparam int STICKY_COUNT = 5;
   localparam int STICKY_FLAG_POS [STICKY_COUNT] = '{15, 11, 10, 9, 8};
   localparam int STICKY_EN_POS   [STICKY_COUNT] = '{7, 3, 2, 1, 0};

   // lower byte bits that software may write as plain storage
   localparam logic [7:0] LOW_BYTE_RW_MASK = 8'hbf;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [1:0] byte_en;
      logic [15:0] wdata;
   } cfg_req_t;

   // one-cycle event pulses, order matches STICKY_FLAG_POS
   typedef struct packed {
      logic end_passthru;
      logic port64_write;
      logic port64_read;
      logic port60_write;
      logic port60_read;
   } trap_events_t;

endpackage

// File: hw/sticky_event_flag.sv
`timescale 1ns/10ps
module sticky_event_flag (
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic ce_in,
   input  wire logic set_in,
   input  wire logic clear_in,
   output logic      flag_out
);
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flag_out <= 1'b0;
      end else if (ce_in) begin
         // set wins over a clear in the same cycle
         if (set_in) begin
            flag_out <= 1'b1;
         end else if (clear_in) begin
            flag_out <= 1'b0;
         end
      end
   end
endmodule // sticky_event_flag

// File: testbench/usb_legacy_smi_status_control_sva.sv
`timescale 1ns/10ps
module usb_legacy_smi_status_control_sva (
   input wire logic                         ref_clk_in,
   input wire logic                         resetn_in,
   input wire legacy_smi_pkg::cfg_req_t     cfg_req_in,
   input wire legacy_smi_pkg::trap_events_t trap_events_in,
   input wire logic                         usb_irq_pending_in,
   input wire logic [15:0]                  cfg_rdata_out,
   input wire logic                         cfg_rd_valid_out,
   input wire logic                         pci_irq_out
);
   import legacy_smi_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   wire logic         rdq = cfg_req_in.rd_en && cfg_req_in.addr == LEGACY_CTRL_OFFSET;
   wire logic         v   = cfg_rd_valid_out;
   wire logic [15:0]  d   = cfg_rdata_out;
   wire trap_events_t e   = trap_events_in;
   property p_ans; cfg_req_in.rd_en |=> v; endproperty
   a_ans: assert property (p_ans) else $error("read not answered");
   property p_end; v && $past(rdq) && $past(e.end_passthru, 2) |-> d[15]; endproperty
   a_end: assert property (p_end) else $error("bit 15 not set");
   property p_w64; v && $past(rdq) && $past(e.port64_write, 2) |-> d[11]; endproperty
   a_w64: assert property (p_w64) else $error("bit 11 not set");
   property p_r64; v && $past(rdq) && $past(e.port64_read, 2) |-> d[10]; endproperty
   a_r64: assert property (p_r64) else $error("bit 10 not set");
   property p_w60; v && $past(rdq) && $past(e.port60_write, 2) |-> d[9]; endproperty
   a_w60: assert property (p_w60) else $error("bit 9 not set");
   property p_usb; v && $past(rdq) |-> d[12] == $past(usb_irq_pending_in, 2); endproperty
   a_usb: assert property (p_usb) else $error("bit 12 wrong");
   property p_res; v |-> !d[14]; endproperty
   a_res: assert property (p_res) else $error("bit 14 set");
   property p_pci; pci_irq_out |-> $past(usb_irq_pending_in); endproperty
   a_pci: assert property (p_pci) else $error("pci irq without cause");
endmodule // usb_legacy_smi_status_control_sva
bind usb_legacy_smi_status_control usb_legacy_smi_status_control_sva u_sva (
   .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cfg_req_in(cfg_req_in),
   .trap_events_in(trap_events_in), .usb_irq_pending_in(usb_irq_pending_in),
   .cfg_rdata_out(cfg_rdata_out), .cfg_rd_valid_out(cfg_rd_valid_out),
   .pci_irq_out(pci_irq_out));

// File: testbench/smm_host_model.sv
`timescale 1ns/10ps
module smm_host_model (
   input  wire logic             ref_clk_in,
   output legacy_smi_pkg::cfg_req_t cfg_req_out
);
   import legacy_smi_pkg::*;
   initial cfg_req_out = '0;
   // caller stands just after an edge; released address, lane and data lines show the inverse, both enables go low
   task automatic xfer(logic [1:0] op, logic [7:0] a, logic [1:0] be, logic [15:0] d);
      cfg_req_out <= {op, a, be, d};
      @(posedge ref_clk_in);
      cfg_req_out <= {2'b00, ~a, ~be, ~d};
      @(posedge ref_clk_in);
   endtask
   function automatic logic [5:0] smi_cause(logic [15:0] r);
      return {r[15] & r[7], r[12] & r[4], r[11:8] & r[3:0]};
   endfunction
endmodule // smm_host_model

// File: testbench/usb_legacy_smi_status_control_tb_top.sv
`timescale 1ns/10ps
module usb_legacy_smi_status_control_tb_top;
   import legacy_smi_pkg::*;
   logic         ref_clk_in, resetn_in, pend, pt, rdv, smi_n, pci, ce;
   cfg_req_t     req;
   trap_events_t ev;
   logic [15:0]  rdata, m, q[$];
   int           fails, n_checks, i;
   initial begin
      ref_clk_in = 0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   smm_host_model u_smm_host_model (.ref_clk_in(ref_clk_in), .cfg_req_out(req));
   usb_legacy_smi_status_control u_usb_legacy_smi_status_control (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce), .cfg_req_in(req),
      .trap_events_in(ev), .usb_irq_pending_in(pend), .passthru_active_in(pt),
      .cfg_rdata_out(rdata), .cfg_rd_valid_out(rdv), .system_mgmt_irq_n_out(smi_n),
      .pci_irq_out(pci));
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      n_checks++;
      if (e !== s) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rd(logic [15:0] e, logic [7:0] a = LEGACY_CTRL_OFFSET);
      q.push_back(e);
      u_smm_host_model.xfer(2'b01, a, 2'b11, 16'h0);
   endtask
   task automatic wr(logic [1:0] be, logic [15:0] d);
      u_smm_host_model.xfer(2'b10, LEGACY_CTRL_OFFSET, be, d);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic pulse(int k);
      ev <= trap_events_t'(5'h10 >> k);
      @(posedge ref_clk_in);
      ev <= '0;
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk_in)
      if (rdv === 1'b1) chk("rdata", q.pop_front(), rdata);
   initial begin
      tick(5000);
      fails++;
      wrap_up;
   end
   initial begin
      resetn_in = 0;
      ce = 1;
      ev = '0;
      pend = 0;
      pt = 0;
      void'($urandom(32'h869a));
      tick(16);
      resetn_in <= 1;
      rd(LEGACY_CTRL_RESET);
      pend <= 1;
      tick(3);
      chk("pci", 16'h1, {15'h0, pci});
      wr(2'b10, 16'h1000);
      tick(2);
      chk("pci", 16'h0, {15'h0, pci});
      rd(16'h1000);
      pend <= 0;
      tick(2);
      rd(16'h0);
      $display("test usb flag done");
      for (i = 0; i < STICKY_COUNT; i++) begin
         m = 16'h1 << STICKY_FLAG_POS[i];
         pulse(i);
         rd(m);
         chk("smi", 16'h1, {15'h0, smi_n});
         wr(2'b10, m);
         rd(16'h0);
      end
      $display("test sticky flags done");
      for (i = 0; i < STICKY_COUNT; i++) begin
         m = 16'h1 << STICKY_EN_POS[i];
         pt <= 1'($urandom);
         wr(2'b01, m);
         pulse(i);
         tick(2);
         chk("smi", 16'h0, {15'h0, smi_n});
         wr(2'b01, m | 16'h20);
         tick(2);
         chk("smi", 16'h1, {15'h0, smi_n});
         u_smm_host_model.xfer(2'b10, 8'hc1, 2'b11, 16'($urandom));
         rd(m | 16'h20 | (16'h1 << STICKY_FLAG_POS[i]) | {9'h0, pt, 6'h0});
         rd(16'h0, 8'($urandom_range(191)));
         wr(2'b11, 16'h1 << STICKY_FLAG_POS[i]);
      end
      $display("test trap enables done");
      pend <= 1;
      wr(2'b01, 16'h10);
      tick(2);
      chk("smi", 16'h0, {15'h0, smi_n});
      pend <= 0;
      tick(3);
      chk("smi", 16'h1, {15'h0, smi_n});
      $display("test usb smi done");
      ce <= 0;
      pulse(0);
      ce <= 1;
      tick(1);
      rd({9'h0, pt, 6'h0} | 16'h10);
      $display("test clock enable done");
      pt <= 0;
      resetn_in <= 0;
      tick(2);
      resetn_in <= 1;
      rd(LEGACY_CTRL_RESET);
      $display("test mid reset done");
      tick(4);
      wrap_up;
   end
endmodule // usb_legacy_smi_status_control_tb_top
